// ===== logic/port_status_cfg.svh
`ifndef PORT_STATUS_CFG_SVH
`define PORT_STATUS_CFG_SVH

// register offsets on the management access port
`define MISC_STATUS_OFS      8'h0F
`define FAULT_STATUS_OFS     8'h10
`define EVENT_STATUS_OFS     8'h11
`define PROFILE_PRIMARY_OFS  8'h12
`define PROFILE_LEGACY_OFS   8'h13
`define CONTROL_PIN_OFS      8'h14

// reset values
`define MISC_STATUS_RST      8'h00
`define FAULT_STATUS_RST     8'h00
`define EVENT_STATUS_RST     8'h00
`define PROFILE_PRIMARY_RST  8'h00
`define PROFILE_LEGACY_RST   8'h00
`define CONTROL_PIN_RST      8'h00
`define UNMAPPED_READ        8'h00

// fault_status field positions
`define FLT_ERROR_BIT        7
`define FLT_DISCHARGE_BIT    6
`define FLT_POWERUP_BIT      5
`define FLT_VBUS_LOW_BIT     4
`define FLT_THERMAL_BIT      3
`define FLT_OVERVOLT_BIT     2
`define FLT_BACKVOLT_BIT     1
`define FLT_OVERCURRENT_BIT  0

// event_status field positions
`define EVT_QUOTA_BIT        7
`define EVT_CONST_CUR_BIT    4
`define EVT_THERMAL_BIT      3
`define EVT_LOW_DRAW_BIT     2
`define EVT_REMOVAL_BIT      1
`define EVT_ATTACH_BIT       0

// profile_status_primary field positions
`define PRF_NO_HS_BIT        7
`define PRF_VS_LOW_BIT       4
`define PRF_CUSTOM_BIT       3
`define PRF_DCP_BIT          2
`define PRF_CDP_BIT          1
`define PRF_PASSTHRU_BIT     0

// quota action code that raises the alert output
`define QUOTA_ACT_ALERT      2'b00
// pass-through flag may be set after power-on
`define PT_ARMED_RST         1'b1

`endif

// ===== logic/port_status_pkg.sv
package port_status_pkg;

  // levels arriving from pins and analog comparators (asynchronous)
  typedef struct packed {
    logic alert_in_n;         // alert pin readback
    logic adet_in_n;          // attach-detect pin readback
    logic over_limit;         // port current above limit threshold
    logic over_r2floor;       // port current above region2_floor
    logic dis_err;            // bus discharge failed
    logic vbus_low;           // bus voltage below keep-out level
    logic tsd;                // thermal shutdown
    logic over_volt;          // source overvoltage
    logic back_v;             // back-voltage detected
    logic therm;              // thermal regulation active
    logic low_draw;           // port current below low-draw level
    logic attach_evt;         // attach detector output
    logic removal_evt;        // removal detector output
    logic mode_select_first;  // first mode-select control
  } pin_cond_t;

  // configuration bits from the configuration bank (same clock)
  typedef struct packed {
    logic       alert_mask;          // suppress alert output
    logic       alert_link;          // informational events raise alert
    logic [1:0] quota_action_sel;    // quota action field
    logic       quota_counter_clear; // quota counter clear control
    logic       quota_enable;        // quota enable control
    logic       port_power_enable;   // port power enable control
    logic       auto_recovery_en;    // auto-recovery fault handling in use
    logic       mode_change;         // pulse: new active mode selected
  } cfg_t;

  // emulation engine and internal status (same clock)
  typedef struct packed {
    logic       custom_profile_ok_ok;     // pulse: custom profile accepted
    logic       dcp_ok;      // pulse: dcp profile accepted
    logic       cdp_ok;      // pulse: cdp profile accepted
    logic       pt_ok;       // pulse: pass-through active
    logic       no_hs;       // level: no handshake indicator
    logic       vs_low;      // level: source below threshold
    logic [6:0] legacy;      // legacy profile indicators
    logic [6:0] pin_state;   // internal control pin states
    logic [3:0] misc_low;    // charge/emulation step status
  } emu_t;

  // register access request from the management serial engine
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acc_t;

  // state of the status bank apart from the flag banks and the pin synchroniser
  typedef struct packed {
    logic [6:0] fault;       // fault flags below the error flag
    logic       error;       // error-state flag
    logic       pt_armed;    // pass-through flag may set
    logic       adet_on;     // attach-detect output asserted
    logic       alert_on;    // alert output asserted
    logic       pwr_d;       // delayed power enable
    logic       therm_d;
    logic       low_d;
    logic       att_d;
    logic       rem_d;
    logic       msf_d;
    logic [7:0] rdata;       // read snapshot
  } bank_state_t;

endpackage : port_status_pkg

// ===== logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // synchronous reset, active low
  input  wire logic [W-1:0] d,      // asynchronous levels
  output      logic [W-1:0] q       // synchronised levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // first stage is read by the second stage only
  always_comb
  begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.s2;

endmodule : pin_sync

`default_nettype wire

// ===== logic/flag_bank.sv
`timescale 1ns/1ps
`default_nettype none

module flag_bank #(
  parameter int W = 1
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // synchronous reset, active low
  input  wire logic [W-1:0] set,    // set requests
  input  wire logic [W-1:0] clr,    // clear requests
  output      logic [W-1:0] q       // flag values
);

  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_t;

  flag_state_t st_reg;
  flag_state_t st_next;

  // a set in the clearing cycle wins so no event is lost
  always_comb
  begin
    st_next.flags = (st_reg.flags & ~clr) | set;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.flags;

endmodule : flag_bank

`default_nettype wire

// ===== logic/port_power_status_bank.sv
`timescale 1ns/1ps
`default_nettype none

`include "port_status_cfg.svh"

module port_power_status_bank
  import port_status_pkg::*;
(
  input  wire logic        clk,                  // system clock, 50 MHz
  input  wire logic        rst_n,                // synchronous reset, active low
  input  wire pin_cond_t   pins,                 // asynchronous pin and analog levels
  input  wire cfg_t        cfg,                  // configuration bits
  input  wire logic        quota_hit,            // pulse: delivered charge reached quota
  input  wire emu_t        emu,                  // emulation and internal status
  input  wire acc_t        acc,                  // register access request
  output      logic [7:0]  rdata,                // read data, valid after read cycle
  output      logic        error_state,          // device is in the error state
  output      logic        alert_out_n,          // alert pin output level
  output      logic        alert_oe,             // alert pin drive enable
  output      logic        attach_detect_out_n,  // attach-detect pin output level
  output      logic        attach_detect_oe      // attach-detect pin drive enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // synchronised inputs

  pin_cond_t   pin_s;
  bank_state_t st_reg;
  bank_state_t st_next;

  pin_sync #(
    .W ($bits(pin_cond_t))
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pins),
    .q     (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // access decode

  logic rd_hit;
  logic rd_fault;
  logic rd_event;
  logic wr_fault;
  logic err_wr_clr;

  // decode of a register read or write
  function automatic logic hit(input acc_t a, input logic [7:0] ofs, input logic wr);
    hit = a.valid && (a.write == wr) && (a.addr == ofs);
  endfunction : hit

  assign rd_hit     = acc.valid && !acc.write;
  assign rd_fault   = hit(acc, `FAULT_STATUS_OFS, 1'b0);
  assign rd_event   = hit(acc, `EVENT_STATUS_OFS, 1'b0);
  assign wr_fault   = hit(acc, `FAULT_STATUS_OFS, 1'b1);
  // only a zero written to the error flag has any effect
  assign err_wr_clr = wr_fault && !acc.wdata[`FLT_ERROR_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // edges of synchronised levels and control

  logic pwr_fall;
  logic therm_rise;
  logic low_rise;
  logic att_evt;
  logic rem_evt;
  logic msf_toggle;

  assign pwr_fall   = st_reg.pwr_d && !cfg.port_power_enable;
  assign therm_rise = pin_s.therm && !st_reg.therm_d;
  assign low_rise   = pin_s.low_draw && !st_reg.low_d;
  assign att_evt    = pin_s.attach_evt && !st_reg.att_d;
  assign rem_evt    = pin_s.removal_evt && !st_reg.rem_d;
  assign msf_toggle = pin_s.mode_select_first != st_reg.msf_d;

  ////////////////////////////////////////////////////////////////////////////////
  // live fault conditions

  logic [6:0] fcond;
  logic       err_clr;
  logic       auto_clr;

  // overcurrent counts only when both thresholds are exceeded
  always_comb
  begin
    fcond = '0;
    fcond[`FLT_OVERCURRENT_BIT] = pin_s.over_limit && pin_s.over_r2floor;
    fcond[`FLT_BACKVOLT_BIT]    = pin_s.back_v;
    fcond[`FLT_OVERVOLT_BIT]    = pin_s.over_volt;
    fcond[`FLT_THERMAL_BIT]     = pin_s.tsd;
    fcond[`FLT_VBUS_LOW_BIT]    = pin_s.vbus_low;
    fcond[`FLT_DISCHARGE_BIT]   = pin_s.dis_err;
  end

  // auto-recovery leaves error once every condition has gone
  assign auto_clr = cfg.auto_recovery_en && st_reg.error && (fcond == '0);
  assign err_clr  = err_wr_clr || pwr_fall || auto_clr;

  ////////////////////////////////////////////////////////////////////////////////
  // clear-on-read event flags: quota, thermal, low draw, removal, attach

  localparam int EV_QUOTA = 4;
  localparam int EV_THERM = 3;
  localparam int EV_LOW   = 2;
  localparam int EV_REM   = 1;
  localparam int EV_ATT   = 0;

  logic [4:0] ev_set;
  logic [4:0] ev_clr;
  logic [4:0] ev_q;

  // each event raises its flag; reads clear, set wins inside flag_bank
  always_comb
  begin
    ev_set           = '0;
    ev_set[EV_QUOTA] = quota_hit;
    ev_set[EV_THERM] = therm_rise;
    ev_set[EV_LOW]   = low_rise;
    ev_set[EV_REM]   = rem_evt;
    ev_set[EV_ATT]   = att_evt;
    ev_clr           = {5{rd_event}};
    ev_clr[EV_QUOTA] = rd_event || cfg.quota_counter_clear || !cfg.quota_enable;
  end

  flag_bank #(
    .W (5)
  ) u_event_flags (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (ev_set),
    .clr   (ev_clr),
    .q     (ev_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // profile indicator flags

  logic [3:0] pf_set;
  logic [3:0] pf_clr;
  logic [3:0] pf_q;
  logic       pt_set;

  // pass-through only sets while armed, so a re-attach alone cannot set it
  assign pt_set = emu.pt_ok && st_reg.pt_armed;

  always_comb
  begin
    pf_set = {emu.custom_profile_ok_ok, emu.dcp_ok, emu.cdp_ok, pt_set};
    pf_clr = {4{pwr_fall || cfg.mode_change || rem_evt}};
  end

  flag_bank #(
    .W (4)
  ) u_profile_flags (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (pf_set),
    .clr   (pf_clr),
    .q     (pf_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register images

  logic [7:0] misc_img;
  logic [7:0] fault_img;
  logic [7:0] event_img;
  logic [7:0] prof_img;
  logic [7:0] legacy_img;
  logic [7:0] pinst_img;

  // images assembled from current state; pin readbacks show asserted as one
  always_comb
  begin
    misc_img   = {2'b00, !pin_s.alert_in_n, !pin_s.adet_in_n, emu.misc_low};
    fault_img  = {st_reg.error, st_reg.fault};
    event_img  = `EVENT_STATUS_RST;
    event_img[`EVT_QUOTA_BIT]     = ev_q[EV_QUOTA];
    event_img[`EVT_CONST_CUR_BIT] = pin_s.over_limit;
    event_img[`EVT_THERMAL_BIT]   = ev_q[EV_THERM];
    event_img[`EVT_LOW_DRAW_BIT]  = ev_q[EV_LOW];
    event_img[`EVT_REMOVAL_BIT]   = ev_q[EV_REM];
    event_img[`EVT_ATTACH_BIT]    = ev_q[EV_ATT];
    prof_img   = `PROFILE_PRIMARY_RST;
    prof_img[`PRF_NO_HS_BIT]      = emu.no_hs;
    prof_img[`PRF_VS_LOW_BIT]     = emu.vs_low;
    prof_img[`PRF_CUSTOM_BIT]     = pf_q[3];
    prof_img[`PRF_DCP_BIT]        = pf_q[2];
    prof_img[`PRF_CDP_BIT]        = pf_q[1];
    prof_img[`PRF_PASSTHRU_BIT]   = pf_q[0];
    legacy_img = {1'b0, emu.legacy};
    pinst_img  = {1'b0, emu.pin_state};
  end

  // read multiplexer; unmapped offsets return zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    unique case (a)
      `MISC_STATUS_OFS:     read_mux = misc_img;
      `FAULT_STATUS_OFS:    read_mux = fault_img;
      `EVENT_STATUS_OFS:    read_mux = event_img;
      `PROFILE_PRIMARY_OFS: read_mux = prof_img;
      `PROFILE_LEGACY_OFS:  read_mux = legacy_img;
      `CONTROL_PIN_OFS:     read_mux = pinst_img;
      default:              read_mux = `UNMAPPED_READ;
    endcase
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic       alert_src;
  logic       quota_alert;
  logic       info_alert;

  // informational and quota sources; profile flags are not a source
  assign quota_alert = ev_q[EV_QUOTA] && (cfg.quota_action_sel == `QUOTA_ACT_ALERT);
  assign info_alert  = cfg.alert_link && (ev_q[EV_THERM] || ev_q[EV_LOW]);
  // removal, attach and profiles stay out of the alert sum
  assign alert_src   = (st_reg.fault != '0) || quota_alert || info_alert;

  always_comb
  begin
    st_next = st_reg;

    // fault flags: a present condition always holds its flag
    if (rd_fault || err_clr)
      st_next.fault = fcond;
    else
      st_next.fault = st_reg.fault | fcond;

    // error flag sets from live fault conditions, write-zero checks remaining faults
    if (err_clr)
      st_next.error = (fcond != '0);
    else
      st_next.error = st_reg.error || (fcond != '0);

    // alert driven from flag sources, not from the error flag
    st_next.alert_on = alert_src && !cfg.alert_mask;

    // attach-detect asserted on attach, released on removal
    if (att_evt)
      st_next.adet_on = 1'b1;
    else if (rem_evt)
      st_next.adet_on = 1'b0;

    // pass-through arming
    if (msf_toggle || cfg.mode_change)
      st_next.pt_armed = 1'b1;
    else if (pt_set)
      st_next.pt_armed = 1'b0;

    // edge history
    st_next.pwr_d   = cfg.port_power_enable;
    st_next.therm_d = pin_s.therm;
    st_next.low_d   = pin_s.low_draw;
    st_next.att_d   = pin_s.attach_evt;
    st_next.rem_d   = pin_s.removal_evt;
    st_next.msf_d   = pin_s.mode_select_first;

    // snapshot taken in the same cycle that clears read-sensitive flags
    if (rd_hit)
      st_next.rdata = read_mux(acc.addr);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg          <= '0;
      st_reg.pt_armed <= `PT_ARMED_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // open-drain pins pull low while enabled
  assign rdata               = st_reg.rdata;
  assign error_state         = st_reg.error;
  assign alert_out_n         = 1'b0;
  assign alert_oe            = st_reg.alert_on;
  assign attach_detect_out_n = 1'b0;
  assign attach_detect_oe    = st_reg.adet_on;

endmodule : port_power_status_bank

`default_nettype wire

// ===== verif/status_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_status_cfg.svh"

module status_bank_checker
  import port_status_pkg::*;
(
  input wire logic       clk,              // system clock
  input wire logic       rst_n,            // synchronous reset, active low
  input wire pin_cond_t  pins,             // pin and analog levels
  input wire cfg_t       cfg,              // configuration bits
  input wire logic       quota_hit,        // quota reached pulse
  input wire acc_t       acc,              // register access request
  input wire logic [7:0] rdata,            // read data
  input wire logic       error_state,      // error flag
  input wire logic       alert_oe,         // alert drive enable
  input wire logic       attach_detect_oe  // attach-detect drive enable
);
  logic oc_live;
  logic any_fault;
  logic rd_evt;
  // live fault conditions and decoded event reads
  assign oc_live   = pins.over_limit && pins.over_r2floor;
  assign any_fault = oc_live || pins.dis_err || pins.vbus_low || pins.tsd
                     || pins.over_volt || pins.back_v;
  assign rd_evt    = acc.valid && !acc.write && acc.addr == `EVENT_STATUS_OFS;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_quiet;
    !any_fault [*4];
  endsequence
  sequence s_clr_write;
    acc.valid && acc.write && acc.addr == `FAULT_STATUS_OFS && acc.wdata == 8'h00;
  endsequence
  sequence s_quota_alert;
    quota_hit && cfg.quota_action_sel == `QUOTA_ACT_ALERT && !cfg.alert_mask
    ##1 !cfg.alert_mask;
  endsequence

  AST_OC_ERROR: assert property (oc_live [*5] |-> error_state)
    else $error("overcurrent did not enter error state");
  AST_OC_ALERT: assert property ((oc_live && !cfg.alert_mask) [*6] |-> alert_oe)
    else $error("overcurrent did not raise alert");
  AST_MASK: assert property (cfg.alert_mask [*2] |-> !alert_oe)
    else $error("alert driven while suppressed");
  AST_PWR_OFF: assert property (s_quiet ##0 $fell(cfg.port_power_enable) |=> !error_state)
    else $error("error flag kept after power disable");
  AST_ERR_WRITE: assert property (s_quiet ##0 s_clr_write |=> !error_state)
    else $error("error flag kept after zero write");
  AST_ATTACH: assert property ($rose(pins.attach_evt) && !pins.removal_evt |-> ##[3:5] attach_detect_oe)
    else $error("attach did not assert attach-detect");
  AST_REMOVAL: assert property ($rose(pins.removal_evt) && !pins.attach_evt |-> ##[3:5] !attach_detect_oe)
    else $error("removal did not release attach-detect");
  AST_CC_LIVE: assert property ($stable(pins.over_limit) [*4] ##0 rd_evt |=> rdata[`EVT_CONST_CUR_BIT] == $past(pins.over_limit))
    else $error("constant-current bit not live");
  AST_QUOTA_ALERT: assert property (s_quota_alert |=> alert_oe)
    else $error("quota reached without alert");
  AST_UNMAPPED: assert property (acc.valid && !acc.write && (acc.addr < `MISC_STATUS_OFS || acc.addr > `CONTROL_PIN_OFS) |=> rdata == 8'h00)
    else $error("unmapped read returned data");
endmodule : status_bank_checker

bind port_power_status_bank status_bank_checker chk_u (
  .clk(clk), .rst_n(rst_n), .pins(pins), .cfg(cfg), .quota_hit(quota_hit), .acc(acc),
  .rdata(rdata), .error_state(error_state), .alert_oe(alert_oe),
  .attach_detect_oe(attach_detect_oe)
);

`default_nettype wire

// ===== verif/status_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module status_host_model
  import port_status_pkg::*;
(
  input  wire logic       clk,    // system clock
  input  wire logic [7:0] rdata,  // read data from the bank
  output var  acc_t       acc     // access request
);
  initial acc = '0;

  // one request held over its taking edge; released lines show inverted values;
  // an idle edge follows so a second call never re-drives acc in the same step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    acc = '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    q = rdata;
    acc = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    @(posedge clk);
    #1;
  endtask : xfer
endmodule : status_host_model

`default_nettype wire

// ===== verif/port_power_status_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_status_cfg.svh"

module port_power_status_bank_tb
  import port_status_pkg::*;
;
  logic       clk;
  logic       rst_n;
  pin_cond_t  pins;
  cfg_t       cfg;
  logic       quota_hit;
  emu_t       emu;
  acc_t       acc;
  logic [7:0] rdata;
  logic       error_state;
  logic       alert_out_n;
  logic       alert_oe;
  logic       attach_detect_out_n;
  logic       attach_detect_oe;
  logic [7:0] q;
  int         error_cnt;
  int         checked;

  port_power_status_bank dut_u (
    .clk(clk), .rst_n(rst_n), .pins(pins), .cfg(cfg), .quota_hit(quota_hit),
    .emu(emu), .acc(acc), .rdata(rdata), .error_state(error_state),
    .alert_out_n(alert_out_n), .alert_oe(alert_oe),
    .attach_detect_out_n(attach_detect_out_n), .attach_detect_oe(attach_detect_oe)
  );
  status_host_model host_u (.clk(clk), .rdata(rdata), .acc(acc));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_u.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    pins = '0;
    pins.alert_in_n = 1'b1;
    pins.adet_in_n = 1'b1;
    cfg = '0;
    cfg.port_power_enable = 1'b1;
    cfg.quota_enable = 1'b1;
    cfg.quota_action_sel = 2'b01;
    quota_hit = 1'b0;
    emu = '0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(3);
    // reset values and two unmapped places
    for (int a = 'h0F; a <= 'h15; a++) rd(8'(a), 8'h00);
    rd(8'h00, 8'h00);
    chk(8'(error_state), 8'h00);
    // overcurrent entry, read clearing and host recovery
    pins.over_limit = 1'b1;
    pins.over_r2floor = 1'b1;
    step(5);
    chk(8'(error_state), 8'h01);
    chk(8'(alert_oe), 8'h01);
    rd(`FAULT_STATUS_OFS, 8'h81);
    rd(`FAULT_STATUS_OFS, 8'h81);
    rd(`EVENT_STATUS_OFS, 8'h10);
    pins.over_r2floor = 1'b0;
    step(4);
    rd(`FAULT_STATUS_OFS, 8'h81);
    rd(`FAULT_STATUS_OFS, 8'h80);
    chk(8'(alert_oe), 8'h00);
    wr(`FAULT_STATUS_OFS, 8'h80);
    wr(`EVENT_STATUS_OFS, 8'h00);
    chk(8'(error_state), 8'h01);
    wr(`FAULT_STATUS_OFS, 8'h00);
    chk(8'(error_state), 8'h00);
    rd(`FAULT_STATUS_OFS, 8'h00);
    pins.over_limit = 1'b0;
    step(3);
    rd(`EVENT_STATUS_OFS, 8'h00);
    // power disable clears error and profile flags
    pins.over_limit = 1'b1;
    pins.over_r2floor = 1'b1;
    step(5);
    pins.over_limit = 1'b0;
    pins.over_r2floor = 1'b0;
    step(3);
    rd(`FAULT_STATUS_OFS, 8'h81);
    emu.dcp_ok = 1'b1;
    step(1);
    emu.dcp_ok = 1'b0;
    rd(`PROFILE_PRIMARY_OFS, 8'h04);
    cfg.port_power_enable = 1'b0;
    step(2);
    chk(8'(error_state), 8'h00);
    rd(`PROFILE_PRIMARY_OFS, 8'h00);
    cfg.port_power_enable = 1'b1;
    // attach and removal events
    pins.attach_evt = 1'b1;
    step(4);
    chk(8'(attach_detect_oe), 8'h01);
    chk(8'(alert_oe), 8'h00);
    rd(`EVENT_STATUS_OFS, 8'h01);
    rd(`EVENT_STATUS_OFS, 8'h00);
    pins.attach_evt = 1'b0;
    pins.removal_evt = 1'b1;
    step(4);
    chk(8'(attach_detect_oe), 8'h00);
    chk(8'(alert_oe), 8'h00);
    rd(`EVENT_STATUS_OFS, 8'h02);
    pins.removal_evt = 1'b0;
    // pass-through arming and profile clearing
    emu.pt_ok = 1'b1;
    step(1);
    emu.pt_ok = 1'b0;
    rd(`PROFILE_PRIMARY_OFS, 8'h01);
    chk(8'(alert_oe), 8'h00);
    chk(8'(attach_detect_oe), 8'h00);
    pins.removal_evt = 1'b1;
    step(4);
    pins.removal_evt = 1'b0;
    pins.attach_evt = 1'b1;
    step(4);
    pins.attach_evt = 1'b0;
    rd(`PROFILE_PRIMARY_OFS, 8'h00);
    emu.pt_ok = 1'b1;
    step(1);
    emu.pt_ok = 1'b0;
    rd(`PROFILE_PRIMARY_OFS, 8'h00);
    rd(`EVENT_STATUS_OFS, 8'h03);
    pins.mode_select_first = 1'b1;
    step(4);
    emu.pt_ok = 1'b1;
    step(1);
    emu = '0;
    rd(`PROFILE_PRIMARY_OFS, 8'h01);
    emu.custom_profile_ok_ok = 1'b1;
    emu.dcp_ok = 1'b1;
    emu.cdp_ok = 1'b1;
    step(1);
    emu = '0;
    rd(`PROFILE_PRIMARY_OFS, 8'h0F);
    cfg.mode_change = 1'b1;
    step(1);
    cfg.mode_change = 1'b0;
    rd(`PROFILE_PRIMARY_OFS, 8'h00);
    // every quota action code, with and without suppression
    for (int i = 0; i < 8; i++)
    begin
      cfg.quota_action_sel = i[1:0];
      cfg.alert_mask = i[2];
      step(2);
      quota_hit = 1'b1;
      step(1);
      quota_hit = 1'b0;
      step(1);
      chk(8'(alert_oe), 8'(i == 0));
      rd(`EVENT_STATUS_OFS, 8'h80);
      step(2);
    end
    // quota flag: set wins over clearing read, then the three clears
    cfg.quota_action_sel = 2'b01;
    cfg.alert_mask = 1'b0;
    quota_hit = 1'b1;
    step(1);
    rd(`EVENT_STATUS_OFS, 8'h80);
    quota_hit = 1'b0;
    rd(`EVENT_STATUS_OFS, 8'h80);
    rd(`EVENT_STATUS_OFS, 8'h00);
    for (int c = 0; c < 2; c++)
    begin
      quota_hit = 1'b1;
      step(1);
      quota_hit = 1'b0;
      cfg.quota_counter_clear = (c == 0);
      cfg.quota_enable = (c == 0);
      step(1);
      cfg.quota_counter_clear = 1'b0;
      cfg.quota_enable = 1'b1;
      rd(`EVENT_STATUS_OFS, 8'h00);
    end
    // thermal and low-draw flags with and without alert link
    for (int k = 0; k < 4; k++)
    begin
      cfg.alert_link = k[0];
      if (k > 1)
        pins.low_draw = 1'b1;
      else
        pins.therm = 1'b1;
      step(5);
      chk(8'(alert_oe), 8'(k[0]));
      rd(`EVENT_STATUS_OFS, (k > 1) ? 8'h04 : 8'h08);
      pins.low_draw = 1'b0;
      pins.therm = 1'b0;
      step(3);
      chk(8'(alert_oe), 8'h00);
    end
    cfg.alert_link = 1'b0;
    // plain level indicators
    emu.legacy = 7'h55;
    emu.pin_state = 7'h2A;
    emu.misc_low = 4'h9;
    emu.no_hs = 1'b1;
    emu.vs_low = 1'b1;
    pins.alert_in_n = 1'b0;
    step(3);
    rd(`PROFILE_LEGACY_OFS, 8'h55);
    rd(`CONTROL_PIN_OFS, 8'h2A);
    rd(`MISC_STATUS_OFS, 8'h29);
    rd(`PROFILE_PRIMARY_OFS, 8'h90);
    // auto-recovery leaves error once the fault is gone, clearing the flags
    cfg.auto_recovery_en = 1'b1;
    pins.over_limit = 1'b1;
    pins.over_r2floor = 1'b1;
    step(5);
    chk(8'(error_state), 8'h01);
    pins.over_r2floor = 1'b0;
    step(5);
    chk(8'(error_state), 8'h00);
    rd(`FAULT_STATUS_OFS, 8'h00);
    chk(8'(alert_out_n), 8'h00);
    chk(8'(attach_detect_out_n), 8'h00);
    finish_test();
  end
endmodule : port_power_status_bank_tb

`default_nettype wire
